// File: verification/secg_clock_gen_asserts.sv
// Port assertions for the clock generator
`timescale 1ns/1ps
module secg_clock_gen_asserts
#(
	parameter int Factor = 10,
	parameter int LockWait = 4
)
(
	// Generator ports
	input wire logic clk,
	input wire logic rst_n,
	input wire logic genEnable,
	input wire logic bit_clock_out,
	input wire logic word_load_pulse_out,
	input wire logic word_clock_out,
	input wire logic lockOut,
	input wire logic rxGenReset
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// Cycles of enable, saturating
	logic [7:0] enCnt_q;
	always_ff @(posedge clk or negedge rst_n)
		if (!rst_n)
			enCnt_q <= 8'h00;
		else if (!genEnable)
			enCnt_q <= 8'h00;
		else if (enCnt_q != 8'hff)
			enCnt_q <= enCnt_q + 8'h01;
	a_rx_rst_inv: assert property (rxGenReset == !lockOut)
		else $error("rx reset not inverse");
	a_bit_toggle: assert property (lockOut && $past(lockOut, 2)
		|-> bit_clock_out != $past(bit_clock_out)) else $error("bit");
	a_load_period: assert property (word_load_pulse_out
		|=> !word_load_pulse_out [*8] ##1 !word_load_pulse_out
		##1 (word_load_pulse_out || !lockOut)) else $error("load");
	a_word_duty: assert property ($rose(word_clock_out)
		|-> (word_clock_out [*5] ##1 !word_clock_out)
		or (##[0:6] !lockOut)) else $error("duty");
	a_load_phase: assert property (word_load_pulse_out
		|-> $past(word_clock_out, 4) && !$past(word_clock_out, 3))
		else $error("phase");
	a_lock_drop: assert property ($fell(genEnable)
		|-> ##[1:6] !lockOut) else $error("drop");
	a_lock_time: assert property ($rose(lockOut)
		|-> enCnt_q >= LockWait + 1 && enCnt_q <= LockWait + 6)
		else $error("lock");
	a_idle_quiet: assert property (!lockOut && !$past(lockOut)
		|-> !bit_clock_out && !word_clock_out) else $error("idle");
endmodule
bind secg_clock_gen secg_clock_gen_asserts
	#(.Factor(Factor), .LockWait(LockWait)) u_chk (.clk, .rst_n,
	.genEnable, .bit_clock_out, .word_load_pulse_out, .word_clock_out,
	.lockOut, .rxGenReset);

// File: verification/secg_clock_gen_tb.sv
// Bench for the external clock generator
`timescale 1ns/1ps
module secg_clock_gen_tb;
	logic clk = 0, rst_n = 0, genEnable = 0;
	logic bitClk, loadP, wordClk, lockOut, rxRst;
	logic [7:0] words;
	int mismatches = 0, cmp_count = 0, n;
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin mismatches++; \
	$display("wrong value t=%0t %h %h", $time, a, b); end end
	always #20 clk = ~clk;
	secg_clock_gen #(.Factor(10), .LockWait(4)) dut (.clk, .rst_n,
		.genEnable, .bit_clock_out(bitClk), .word_load_pulse_out(loadP),
		.word_clock_out(wordClk), .lockOut, .rxGenReset(rxRst));
	// bit clock goes to the serial side only, never the model logic
	secg_rx_model u_rx (.clk, .loadEn(loadP), .rxRst, .words);
	task end_of_test;
		$display("checks %0d wrong %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// Bounded wait for a lock level
	task wait_lock(logic v);
		for (n = 0; lockOut !== v && n < 40; n++)
			@(negedge clk);
		if (n == 40)
		begin
			mismatches++;
			end_of_test;
		end
	endtask
	task t_lock;
		genEnable = 1;
		wait_lock(1);
		`CHK(n inside {[5:9]}, 1'b1)
		`CHK(bitClk, 1'b1)
		`CHK(rxRst, 1'b0)
		$display("lock done");
	endtask
	task t_words;
		int tg, hi;
		logic pb;
		logic [7:0] w0;
		tg = 0;
		hi = 0;
		pb = bitClk;
		w0 = words;
		repeat (40)
		begin
			@(negedge clk);
			tg += (bitClk !== pb);
			pb = bitClk;
			hi += wordClk;
		end
		`CHK(tg, 40)
		// word clock is high for half of each word, 20 of 40 cycles
		`CHK(hi, 20)
		`CHK(words - w0, 8'h04)
		$display("words done");
	endtask
	task t_drop;
		genEnable = 0;
		wait_lock(0);
		repeat (2) @(negedge clk);
		`CHK({rxRst, words, bitClk}, {1'b1, 8'h00, 1'b0})
		genEnable = 1;
		repeat (2) @(negedge clk);
		genEnable = 0;
		repeat (12) @(negedge clk);
		`CHK(lockOut, 1'b0)
		$display("drop done");
	endtask
	initial
	begin
		repeat (3) @(negedge clk);
		`CHK(rxRst, 1'b1)
		rst_n = 1;
		t_lock;
		t_words;
		t_drop;
		t_lock;
		t_words;
		end_of_test;
	end
endmodule

// File: verification/secg_rx_model.sv
// Receiver channel model fed by the generator
`timescale 1ns/1ps
module secg_rx_model
(
	// Generator side
	input wire logic clk,
	input wire logic loadEn,
	input wire logic rxRst,
	output logic [7:0] words
);
	// reset without lock, word per load
	always_ff @(posedge clk or posedge rxRst)
		if (rxRst)
			words <= 8'h00;
		else if (loadEn)
			words <= words + 8'h01;
endmodule

// File: verilog/secg_clock_gen.sv
// External clock generator for a serializer/deserializer pair
`timescale 1ns/1ps
module secg_clock_gen
	import secg_pkg::*;
#(
	parameter int Factor = SerFactor,
	parameter int LockWait = LockWaitCycles
)
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Asynchronous enable from outside
	input wire logic genEnable,
	// Clocks and strobes to the channels
	output logic bit_clock_out,
	output logic word_load_pulse_out,
	output logic word_clock_out,
	// Lock status and receiver reset
	output logic lockOut,
	output logic rxGenReset
);
	////////////////////////////////////////////////////////////////
	// Enable synchronisation
	logic enSync;
	secg_sync2 uSync
	(
		.clk(clk),
		.rst_n(rst_n),
		.asyncIn(genEnable),
		.syncOut(enSync)
	);

	////////////////////////////////////////////////////////////////
	// Lock sequencing
	secg_state_t state_q;
	secg_state_t state_d;
	logic [LockCntWidth-1:0] wait_q;
	logic [LockCntWidth-1:0] wait_d;
	localparam logic [LockCntWidth-1:0] WaitLast =
		LockCntWidth'(LockWait - 1);
	wire waitDone = (wait_q == WaitLast);
	wire locked = (state_q == SecgLocked);

	// Next state: idle, settle, then locked until disabled
	always_comb
	begin
		state_d = state_q;
		wait_d = '0;
		case (state_q)
			SecgIdle:
				if (enSync)
					state_d = SecgWait;
			SecgWait:
			begin
				wait_d = wait_q + LockCntWidth'(1);
				if (!enSync)
					state_d = SecgIdle;
				else if (waitDone)
					state_d = SecgLocked;
			end
			SecgLocked:
				if (!enSync)
					state_d = SecgIdle;
			default:
				state_d = SecgIdle;
		endcase
	end

	// State registers
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_q <= SecgIdle;
			wait_q <= '0;
		end
		else
		begin
			state_q <= state_d;
			wait_q <= wait_d;
		end
	end

	////////////////////////////////////////////////////////////////
	// Bit position within a word
	logic [SerFactorWidth-1:0] bitPos;
	// Counter restarts clean
	// Counting only while locked puts position zero on the first locked
	// cycle, so the first word clock after lock is a full-width pulse
	// instead of a runt left over from the settle time
	secg_word_counter #(.Factor(Factor)) uCount
	(
		.clk(clk),
		.rst_n(rst_n),
		.run(locked),
		.bitPos(bitPos)
	);

	////////////////////////////////////////////////////////////////
	// Derived waveforms, one clk period stands for one bit here
	localparam logic [SerFactorWidth-1:0] LoadPos =
		SerFactorWidth'(Factor - LoadLead);
	localparam logic [SerFactorWidth-1:0] HalfPos =
		SerFactorWidth'(Factor / 2);
	wire loadNext = locked && (bitPos == LoadPos);
	wire wordNext = locked && (bitPos < HalfPos);

	// Bit toggles every cycle while locked; a preset to the inverted level
	// while unlocked gives the half period shift against the reference grid
	logic bit_q;
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			bit_q <= 1'h0;
		else if (!locked)
			bit_q <= BitClkPhaseInv;
		else
			bit_q <= ~bit_q;
	end

	// Outputs straight from flip-flops
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			bit_clock_out <= 1'h0;
			word_load_pulse_out <= 1'h0;
			word_clock_out <= 1'h0;
			lockOut <= 1'h0;
			rxGenReset <= 1'h1;
		end
		else
		begin
			bit_clock_out <= locked & bit_q;
			word_load_pulse_out <= loadNext;
			word_clock_out <= wordNext;
			lockOut <= locked;
			rxGenReset <= ~locked;
		end
	end
	// All channel clocks come from here
endmodule

// File: verilog/secg_pkg.sv
// Constants shared by the external serial clock generator
package secg_pkg;
	// Serialization factor and lock timing
	localparam int SerFactor = 10;
	localparam int SerFactorWidth = 8;
	localparam int LockWaitNs = 1000;
	localparam int ClkPeriodNs = 40;
	localparam int LockWaitCycles = (LockWaitNs + ClkPeriodNs - 1) / ClkPeriodNs;
	localparam int LockCntWidth = 16;
	// Phase of the bit clock against the reference, in bit clock half periods
	localparam logic [0:0] BitClkPhaseInv = 1'h1;
	// Load pulse sits this many bits before the end of the word
	localparam int LoadLead = 2;
	// Generator states
	typedef enum logic [1:0] {SecgIdle, SecgWait, SecgLocked} secg_state_t;
endpackage

// File: verilog/secg_sync2.sv
// Two-stage synchroniser for one asynchronous level
`timescale 1ns/1ps
module secg_sync2
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Level in and out
	input wire logic asyncIn,
	output logic syncOut
);
	// First stage, read only by the second
	logic meta_q;
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			meta_q <= 1'h0;
			syncOut <= 1'h0;
		end
		else
		begin
			meta_q <= asyncIn;
			syncOut <= meta_q;
		end
	end
endmodule

// File: verilog/secg_word_counter.sv
// Bit position counter, wraps once per parallel word
`timescale 1ns/1ps
module secg_word_counter
	import secg_pkg::*;
#(
	parameter int Factor = SerFactor
)
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Count enable and position
	input wire logic run,
	output logic [SerFactorWidth-1:0] bitPos
);
	localparam logic [SerFactorWidth-1:0] LastPos =
		SerFactorWidth'(Factor - 1);
	// Held at zero while stopped so phase restarts identically on lock
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			bitPos <= '0;
		else if (!run || bitPos == LastPos)
			bitPos <= '0;
		else
			bitPos <= bitPos + SerFactorWidth'(1);
	end
endmodule
